// File: hdl/icrg_cfg.svh
`ifndef ICRG_CFG_SVH
`define ICRG_CFG_SVH

// ==========================================================
// address field positions, as carried on host_addr_i[9:3]
`define ICRG_ADDR_HI          9
`define ICRG_ADDR_LO          3
`define ICRG_BASE_HI          9
`define ICRG_BASE_LO          5
`define ICRG_SEL_BIT          4
`define ICRG_SUB_BIT          3

// ==========================================================
// levels and reset values
`define ICRG_READY_LOW        1'b0
`define ICRG_REQ_RELEASED     1'b1
`define ICRG_OE_RST           1'b0
`define ICRG_SEL_N_RST        1'b1
`define ICRG_CNT_RST          16'h0000

// ==========================================================
// widths and timing counts
`define ICRG_CNT_W            16
`define ICRG_SYNC_STAGES      2
`define ICRG_WIN_HOLD_EDGES   1

`endif

// File: hdl/icrg_pkg.sv
package icrg_pkg;

    // remote word transfer progress, gray along the loop
    typedef enum logic [1:0] {
        ICRG_IDLE    = 2'b00,
        ICRG_FETCHED = 2'b01,
        ICRG_LATCHED = 2'b11,
        ICRG_REQUEST = 2'b10
    } icrg_xfer_e;

    typedef logic [4:0] icrg_base_t;

endpackage : icrg_pkg

// File: hdl/icrg_sync.sv
`timescale 1ns/1ps
`include "icrg_cfg.svh"

module icrg_sync #(
    parameter int WIDTH = 1
) (
    // clock of the receiving domain
    input  wire logic             clk_i,
    // asynchronous levels in, settled levels out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ==========================================================
    // two stage chain; first stage only feeds the second
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] hold_q;

    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        hold_q <= meta_q;
    end

    assign q_o = hold_q;

endmodule : icrg_sync

// File: hdl/icrg_top.sv
`timescale 1ns/1ps
`include "icrg_cfg.svh"

module icrg_top
    import icrg_pkg::*;
#(
    parameter int CNT_W = `ICRG_CNT_W
) (
    // system clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // link clock: inverted system clock of the host bus
    input  wire logic             sysclk_inv_i,
    // host bus address and strobes
    input  wire logic [9:3]       host_addr_i,
    input  wire logic             bale_i,
    input  wire logic             host_read_strobe_n_i,
    input  wire logic             host_write_strobe_n_i,
    input  wire logic             mem_read_strobe_n_i,
    input  wire logic             mem_write_strobe_n_i,
    input  wire logic             wide_transfer_flag_i,
    // card configuration
    input  wire logic [4:0]       base_addr_i,
    input  wire logic             early_jumper_i,
    // network controller handshake
    input  wire logic             register_ack_n_i,
    input  wire logic             port_word_request_i,
    input  wire logic             port_word_request_oe_i,
    input  wire logic             buffer_read_strobe_i,
    input  wire logic             port_latch_write_i,
    input  wire logic             port_read_ack_i,
    // shared ready line, open drain
    output logic                  ready_out_n_o,
    output logic                  ready_drive_enable_o,
    // individual drivers onto the ready line
    output logic                  read_path_ready_n_o,
    output logic                  read_path_oe_o,
    output logic                  write_path_ready_n_o,
    output logic                  write_path_oe_o,
    output logic                  early_ready_n_o,
    output logic                  early_oe_o,
    // status
    output logic                  card_select_n_o,
    output logic                  early_timing_window_o,
    output icrg_xfer_e            xfer_state_o,
    output logic                  word_done_o,
    output logic [CNT_W-1:0]      word_count_o
);

    // ==========================================================
    // function: base address match on bits nine to five
    function automatic logic addr_match(input logic [9:3] a, input icrg_base_t b);
        addr_match = (a[`ICRG_BASE_HI:`ICRG_BASE_LO] == b);
    endfunction : addr_match

    // ==========================================================
    // pin synchronisers, system domain
    localparam int NS = 7 + 5 + 13;

    logic          bale_l;
    logic          rst_b_l;
    logic          win_hold_q;
    logic          win_l;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] pin_s;

    assign pin_raw = {host_addr_i, base_addr_i, host_read_strobe_n_i,
                      host_write_strobe_n_i, mem_read_strobe_n_i,
                      mem_write_strobe_n_i, wide_transfer_flag_i, early_jumper_i,
                      register_ack_n_i, port_word_request_i, port_word_request_oe_i,
                      buffer_read_strobe_i, port_latch_write_i, port_read_ack_i,
                      win_l};

    icrg_sync #(
        .WIDTH (NS)
    ) u_sync_sys (
        .clk_i (clk_i),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    logic [9:3]  addr_s;
    icrg_base_t  base_s;
    logic        ior_n_s;
    logic        iow_n_s;
    logic        memr_n_s;
    logic        memw_n_s;
    logic        wide_s;
    logic        jumper_s;
    logic        ack_n_s;
    logic        req_s;
    logic        req_oe_s;
    logic        brd_s;
    logic        plw_s;
    logic        rdack_s;
    logic        win_s;

    assign {addr_s, base_s, ior_n_s, iow_n_s, memr_n_s, memw_n_s, wide_s,
            jumper_s, ack_n_s, req_s, req_oe_s, brd_s, plw_s, rdack_s,
            win_s} = pin_s;

    // ==========================================================
    // link domain: early timing window on the inverted system clock

    icrg_sync #(
        .WIDTH (2)
    ) u_sync_link (
        .clk_i (sysclk_inv_i),
        .d_i   ({bale_i, rst_b_i}),
        .q_o   ({bale_l, rst_b_l})
    );

    // stays up for one link edge after bale falls, time for a strobe to show
    always_ff @(posedge sysclk_inv_i) begin
        if (!rst_b_l) begin
            win_hold_q <= `ICRG_OE_RST;
        end else begin
            win_hold_q <= bale_l;
        end
    end

    assign win_l = bale_l | win_hold_q;

    // ==========================================================
    // address decode
    logic card_sel;
    logic slave_acc;
    logic port_acc;
    logic req_eff;
    logic strobe_on;

    assign card_sel  = addr_match(addr_s, base_s);
    assign slave_acc = !addr_s[`ICRG_SEL_BIT];
    assign port_acc  = addr_s[`ICRG_SEL_BIT] && !addr_s[`ICRG_SUB_BIT];
    // floating request reads as released, else the host could hang forever
    assign req_eff   = req_oe_s ? req_s : `ICRG_REQ_RELEASED;
    assign strobe_on = !ior_n_s || !iow_n_s;

    logic wait_cause;
    assign wait_cause = (slave_acc && ack_n_s) || (port_acc && !req_eff);

    // ==========================================================
    // normal timing: read and write path drivers
    logic rd_oe_q;
    logic wr_oe_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_oe_q <= `ICRG_OE_RST;
        end else begin
            rd_oe_q <= card_sel && !ior_n_s && wait_cause;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_oe_q <= `ICRG_OE_RST;
        end else begin
            wr_oe_q <= card_sel && !iow_n_s && wait_cause;
        end
    end

    // ==========================================================
    // early timing: address decode and wait cause without I/O strobe, inside the bale window, with jumper and wide flag set
    logic early_oe_q;

    // no I/O strobe term here, only idle memory strobes, so a host sampling early still sees not-ready
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            early_oe_q <= `ICRG_OE_RST;
        end else begin
            early_oe_q <= jumper_s && wide_s && win_s && card_sel && wait_cause
                          && memr_n_s && memw_n_s;
        end
    end

    // ==========================================================
    // select and window status
    logic sel_n_q;
    logic win_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sel_n_q <= `ICRG_SEL_N_RST;
            win_q   <= `ICRG_OE_RST;
        end else begin
            sel_n_q <= !card_sel;
            win_q   <= win_s;
        end
    end

    // ==========================================================
    // remote word transfer tracking
    icrg_xfer_e       xfer_q;
    logic             done_q;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            xfer_q <= ICRG_IDLE;
        end else begin
            unique case (xfer_q)
                ICRG_IDLE: begin
                    if (brd_s) xfer_q <= ICRG_FETCHED;
                end
                ICRG_FETCHED: begin
                    if (plw_s) xfer_q <= ICRG_LATCHED;
                end
                ICRG_LATCHED: begin
                    if (req_oe_s && req_s) xfer_q <= ICRG_REQUEST;
                end
                ICRG_REQUEST: begin
                    if (rdack_s) xfer_q <= ICRG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            done_q <= `ICRG_OE_RST;
            cnt_q  <= CNT_W'(`ICRG_CNT_RST);
        end else begin
            done_q <= (xfer_q == ICRG_REQUEST) && rdack_s;
            if ((xfer_q == ICRG_REQUEST) && rdack_s) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // outputs; every driver only ever pulls low
    assign ready_out_n_o         = `ICRG_READY_LOW;
    assign read_path_ready_n_o   = `ICRG_READY_LOW;
    assign write_path_ready_n_o  = `ICRG_READY_LOW;
    assign early_ready_n_o       = `ICRG_READY_LOW;
    assign read_path_oe_o        = rd_oe_q;
    assign write_path_oe_o       = wr_oe_q;
    assign early_oe_o            = early_oe_q;
    assign ready_drive_enable_o  = rd_oe_q || wr_oe_q || early_oe_q;
    assign card_select_n_o       = sel_n_q;
    assign early_timing_window_o = win_q;
    assign xfer_state_o          = xfer_q;
    assign word_done_o           = done_q;
    assign word_count_o          = cnt_q;

    // ==========================================================
    // assertions
    sequence s_port_wait;
        card_sel && port_acc && !req_eff && strobe_on;
    endsequence

    sequence s_word_served;
        (xfer_q == ICRG_REQUEST) && rdack_s;
    endsequence

    property p_drive_low_only;
        @(posedge clk_i) disable iff (!rst_b_i)
        ready_drive_enable_o |-> (ready_out_n_o == 1'b0) && $past(card_sel && wait_cause);
    endproperty
    a_drive_low_only: assert property (p_drive_low_only)
        else $error("ready line enabled without a selected wait cause");
    property p_slave_wait;
        @(posedge clk_i) disable iff (!rst_b_i)
        (card_sel && slave_acc && ack_n_s && !ior_n_s) |=> rd_oe_q;
    endproperty
    a_slave_wait: assert property (p_slave_wait)
        else $error("slave read not wait-stated");
    property p_port_wait;
        @(posedge clk_i) disable iff (!rst_b_i)
        s_port_wait |=> (rd_oe_q || wr_oe_q);
    endproperty
    a_port_wait: assert property (p_port_wait)
        else $error("port access not wait-stated");
    property p_port_release;
        @(posedge clk_i) disable iff (!rst_b_i)
        (port_acc && req_eff) |=> !(rd_oe_q || wr_oe_q);
    endproperty
    a_port_release: assert property (p_port_release)
        else $error("wait held after port word request");
    property p_no_strobe_no_wait;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ior_n_s && iow_n_s) |=> !(rd_oe_q || wr_oe_q);
    endproperty
    a_no_strobe_no_wait: assert property (p_no_strobe_no_wait)
        else $error("normal wait without strobe");
    property p_early_mem_float;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!memr_n_s || !memw_n_s || !jumper_s || !wide_s) |=> !early_oe_q;
    endproperty
    a_early_mem_float: assert property (p_early_mem_float)
        else $error("early drive during memory cycle or while disabled");
    property p_early_decode;
        @(posedge clk_i) disable iff (!rst_b_i)
        (jumper_s && wide_s && win_s && memr_n_s && memw_n_s && card_sel
         && ((slave_acc && ack_n_s) || (port_acc && !req_eff))) |=> early_oe_q;
    endproperty
    a_early_decode: assert property (p_early_decode)
        else $error("early drive missing on address decode");
    property p_window_close;
        @(posedge sysclk_inv_i) disable iff (!rst_b_l)
        (bale_l ##1 !bale_l) |=> !win_l;
    endproperty
    a_window_close: assert property (p_window_close)
        else $error("early window not closed after bale fell");
    property p_word_count;
        @(posedge clk_i) disable iff (!rst_b_i)
        s_word_served |=> word_done_o && (cnt_q == $past(cnt_q) + CNT_W'(1))
                          && (xfer_q == ICRG_IDLE);
    endproperty
    a_word_count: assert property (p_word_count)
        else $error("served word not counted");
    property p_select;
        @(posedge clk_i) disable iff (!rst_b_i)
        card_sel |=> !card_select_n_o;
    endproperty
    a_select: assert property (p_select)
        else $error("card select missing on address match");

endmodule : icrg_top

// File: tb/icrg_nic_model.sv
`timescale 1ns/1ps

module icrg_nic_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // bench commands
    input  wire logic       cfg_i,
    input  wire logic       go_i,
    input  wire logic [3:0] lat_i,
    // host side as seen by the controller
    input  wire logic       host_strobe_n_i,
    input  wire logic       sa4_i,
    // controller outputs
    output logic            register_ack_n_o,
    output logic            port_word_request_o,
    output logic            port_word_request_oe_o,
    output logic            buffer_read_strobe_o,
    output logic            port_latch_write_o,
    output logic            port_read_ack_o
);
    // ==========================================================
    // word loop
    logic [2:0] step_q;
    logic [3:0] cnt_q;
    logic [3:0] ack_cnt_q;
    // unprogrammed controller leaves the line to the pull-up
    assign port_word_request_oe_o = cfg_i;
    assign port_word_request_o    = cfg_i ? (step_q >= 3'h3) : 1'b1;
    assign buffer_read_strobe_o   = (step_q == 3'h1);
    assign port_latch_write_o     = (step_q == 3'h2);
    assign port_read_ack_o        = (step_q == 3'h4);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            step_q <= 3'h0;
            cnt_q  <= 4'h0;
        end else begin
            case (step_q)
                3'h0: if (go_i) step_q <= 3'h1;
                3'h1: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q >= lat_i) step_q <= 3'h2;
                end
                3'h2: step_q <= 3'h3;
                3'h3: if (!host_strobe_n_i && sa4_i) step_q <= 3'h4;
                default: begin
                    cnt_q <= 4'h0;
                    // request held until the host lets go of its strobe
                    if (host_strobe_n_i) step_q <= 3'h0;
                end
            endcase
        end
    end
    // ==========================================================
    // register acknowledge, slow or prompt
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || host_strobe_n_i || sa4_i) begin
            ack_cnt_q <= 4'h0;
        end else if (ack_cnt_q != 4'hf) begin
            ack_cnt_q <= ack_cnt_q + 4'h1;
        end
    end
    assign register_ack_n_o = !((ack_cnt_q > lat_i) && !host_strobe_n_i);
endmodule : icrg_nic_model

// File: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import icrg_pkg::*;
    localparam logic [4:0] BASE = 5'h0a;
    logic       clk_i, sysclk, rst_b, bale, ior_n, iow_n, memr_n, memw_n, wide, jmp;
    logic       cfg, go;
    logic [3:0] lat;
    logic [6:0] addr;
    wire        ack_n, wreq, wreq_oe, brd, plw, rdack, rdy, en, rd_n, rd_oe, wr_n, wr_oe;
    wire        er_n, e_oe, sel_n, win, done;
    icrg_xfer_e st;
    wire [15:0] cnt;
    int         n_fail, num_checks, i;

    icrg_nic_model nic (.clk_i(clk_i), .rst_b_i(rst_b), .cfg_i(cfg), .go_i(go),
        .lat_i(lat), .host_strobe_n_i(ior_n & iow_n), .sa4_i(addr[1]),
        .register_ack_n_o(ack_n), .port_word_request_o(wreq), .port_word_request_oe_o(wreq_oe),
        .buffer_read_strobe_o(brd), .port_latch_write_o(plw), .port_read_ack_o(rdack));
    icrg_top uut (.clk_i(clk_i), .rst_b_i(rst_b), .sysclk_inv_i(sysclk), .host_addr_i(addr),
        .bale_i(bale), .host_read_strobe_n_i(ior_n), .host_write_strobe_n_i(iow_n),
        .mem_read_strobe_n_i(memr_n), .mem_write_strobe_n_i(memw_n),
        .wide_transfer_flag_i(wide), .base_addr_i(BASE), .early_jumper_i(jmp),
        .register_ack_n_i(ack_n), .port_word_request_i(wreq), .port_word_request_oe_i(wreq_oe),
        .buffer_read_strobe_i(brd), .port_latch_write_i(plw), .port_read_ack_i(rdack),
        .ready_out_n_o(rdy), .ready_drive_enable_o(en), .read_path_ready_n_o(rd_n),
        .read_path_oe_o(rd_oe), .write_path_ready_n_o(wr_n), .write_path_oe_o(wr_oe),
        .early_ready_n_o(er_n), .early_oe_o(e_oe), .card_select_n_o(sel_n),
        .early_timing_window_o(win), .xfer_state_o(st), .word_done_o(done),
        .word_count_o(cnt));

    // ==========================================================
    // checking
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    // ==========================================================
    // scenarios
    task automatic t_slave(input logic rd);
        addr = {BASE, 2'b00};
        ior_n = !rd;
        iow_n = rd;
        cyc(4);
        chk("rd_oe", rd, rd_oe);
        chk("wr_oe", !rd, wr_oe);
        chk("en", 1'b1, en);
        chk("sel_n", 1'b0, sel_n);
        cyc(12);
        chk("en_ack", 1'b0, en);
        ior_n = 1'b1;
        iow_n = 1'b1;
        cyc(5);
    endtask : t_slave
    task automatic t_decode();
        addr = {BASE ^ 5'h01, 2'b00};
        ior_n = 1'b0;
        cyc(5);
        chk("en_miss", 1'b0, en);
        chk("sel_miss", 1'b1, sel_n);
        addr = {BASE, 2'b10};
        ior_n = 1'b1;
        cyc(5);
        chk("en_nostrobe", 1'b0, en);
        iow_n = 1'b0;
        cyc(5);
        chk("wr_oe_port", 1'b1, wr_oe);
        addr = {BASE, 2'b11};
        cyc(5);
        chk("en_sa3", 1'b0, en);
        addr = {BASE, 2'b10};
        cfg = 1'b0;
        cyc(5);
        chk("en_float", 1'b0, en);
        iow_n = 1'b1;
        cfg = 1'b1;
        cyc(5);
    endtask : t_decode
    task automatic t_remote(input logic [3:0] l, input logic [15:0] n);
        lat = l;
        addr = {BASE, 2'b10};
        ior_n = 1'b0;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(3);
        chk("rd_oe_wait", 1'b1, rd_oe);
        for (i = 0; i < 40 && !wreq; i++) cyc(1);
        cyc(4);
        chk("rd_oe_req", 1'b0, rd_oe);
        ior_n = 1'b1;
        for (i = 0; i < 12 && !done; i++) cyc(1);
        chk("done", 1'b1, done);
        cyc(1);
        chk("done_pulse", 1'b0, done);
        cyc(6);
        chk("count", n, cnt);
        chk("state", ICRG_IDLE, st);
    endtask : t_remote
    task automatic t_early(input logic j, input logic w);
        jmp = j;
        wide = w;
        addr = {BASE, 2'b00};
        bale = 1'b1;
        cyc(16);
        chk("win", 1'b1, win);
        chk("e_oe", j & w, e_oe);
        chk("rd_oe_early", 1'b0, rd_oe);
        memr_n = 1'b0;
        cyc(5);
        chk("e_oe_mem", 1'b0, e_oe);
        memr_n = 1'b1;
        memw_n = 1'b0;
        cyc(5);
        chk("e_oe_memw", 1'b0, e_oe);
        memw_n = 1'b1;
        cyc(5);
        bale = 1'b0;
        cyc(24);
        chk("win_off", 1'b0, win);
        chk("e_oe_off", 1'b0, e_oe);
        jmp = 1'b0;
    endtask : t_early

    // ==========================================================
    // clocks, watchdog, sequence
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        sysclk = 1'b0;
        #7;
        forever #32 sysclk = ~sysclk;
    end
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {bale, wide, jmp, go} = 4'h0;
        {ior_n, iow_n, memr_n, memw_n, cfg} = 5'h1f;
        rst_b = 1'b0;
        lat = 4'h6;
        addr = 7'h00;
        cyc(3);
        chk("oe_rst", 3'h0, {rd_oe, wr_oe, e_oe});
        chk("sel_rst", 1'b1, sel_n);
        chk("cnt_rst", 16'h0000, cnt);
        chk("lows", 4'h0, {rdy, rd_n, wr_n, er_n});
        rst_b = 1'b1;
        cyc(4);
        t_slave(1'b1);
        t_slave(1'b0);
        t_decode();
        t_remote(4'h8, 16'h0001);
        t_remote(4'h1, 16'h0002);
        t_early(1'b1, 1'b1);
        t_early(1'b1, 1'b0);
        t_early(1'b0, 1'b1);
        print_verdict();
    end
endmodule : tb_top
